// [design/pdp_db2lin.sv]
// Converts a net attenuation in half-dB steps into a linear gain.
// Purely combinational; the caller registers the product it feeds.
`timescale 1ns/1ps
`default_nettype none
module pdp_db2lin
  import pdp_pkg::*;
(
  input  wire logic signed [ATTW:0] att_net,
  output logic         [GW-1:0]     gain
);

  logic [ATTW:0] e;
  logic [ATTW:0] sh;
  logic [ATTW:0] idx;
  logic [GW-1:0] base;

  // ---------------------------------------------------------------
  // Octave shift plus table fraction
  // ---------------------------------------------------------------
  // Boost is folded in as negative attenuation, so offset first
  always_comb
  begin
    e    = att_net + BOOST_OFS;
    sh   = e / STEPS_6DB;
    idx  = e % STEPS_6DB;
    base = {FRAC_TAB[idx[3:0]], 2'b00};
    if (att_net < -$signed(BOOST_OFS) || sh >= (ATTW+1)'(GW))
      gain = '0;                                  // Beyond range reads as silence
    else
      gain = base >> sh;
  end

endmodule : pdp_db2lin
`default_nettype wire

// [design/pdp_limiter.sv]
// Peak limiter gain tracker: one update per output sample.
// Expects the magnitude of the last limited output sample.
`timescale 1ns/1ps
`default_nettype none
module pdp_limiter
  import pdp_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            tick,
  input  wire logic [22:0]     mag,
  input  wire logic            run,
  input  wire logic            enable,
  input  wire logic [3:0]      atk_code,
  input  wire logic [3:0]      dcy_code,
  input  wire logic [2:0]      lvl_code,
  output logic      [ATTW-1:0] att
);

  logic [ATTW-1:0] att_ff, nxt_att;
  logic [15:0]     acc_ff, nxt_acc;
  logic [2:0]      lvl;
  logic [3:0]      atk_k, dcy_k;
  logic [19:0]     sum;
  logic [ATTW-1:0] steps;

  assign att = att_ff;

  // ---------------------------------------------------------------
  // Attack / decay stepping
  // ---------------------------------------------------------------
  // A fractional accumulator keeps the long codes exact in samples,
  // so every time scales with the sample rate
  always_comb
  begin
    lvl     = (lvl_code > LVL_CAP) ? LVL_CAP : lvl_code;
    atk_k   = (atk_code > RATE_CAP) ? RATE_CAP : atk_code;
    dcy_k   = (dcy_code > RATE_CAP) ? RATE_CAP : dcy_code;
    nxt_att = att_ff;
    nxt_acc = acc_ff;
    sum     = '0;
    steps   = '0;
    if (!run || !enable)
    begin
      nxt_att = '0;
      nxt_acc = '0;
    end
    else if (tick)
    begin
      if (mag > THR_TAB[lvl])
      begin
        sum     = {4'h0, acc_ff} + (ATK_INC0 >> atk_k);
        steps   = ATTW'(sum[19:16]);
        nxt_acc = sum[15:0];
        nxt_att = (att_ff + steps > LIM_MAX) ? LIM_MAX : att_ff + steps;
      end
      else if (mag < THR_TAB[lvl + 3'h1] && att_ff != '0)
      begin
        sum     = {4'h0, acc_ff} + (DCY_INC0 >> dcy_k);
        steps   = ATTW'(sum[19:16]);
        nxt_acc = sum[15:0];
        nxt_att = (att_ff > steps) ? att_ff - steps : '0;
      end
      else
        nxt_acc = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      att_ff <= '0;
      acc_ff <= '0;
    end
    else
    begin
      att_ff <= nxt_att;
      acc_ff <= nxt_acc;
    end
  end

endmodule : pdp_limiter
`default_nettype wire

// [design/pdp_pkg.sv]
// Shared constants for the playback digital path: register map, fields,
// reset values, gain tables and limiter timing.
// Assumes a single 125 MHz clock and one sample strobe per sample period.
package pdp_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DW      = 24;          // Sample width
  localparam int GW      = 18;          // Linear gain, unity at 2^15
  localparam int ATTW    = 10;          // Attenuation in half-dB steps
  localparam int AW      = 8;           // AXI address bits used
  localparam int UNITY_SH = 15;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_PWR  = 6'h03;
  localparam logic [5:0] IDX_CTRL = 6'h0A;
  localparam logic [5:0] IDX_VOL  = 6'h0B;
  localparam logic [5:0] IDX_LIM1 = 6'h18;
  localparam logic [5:0] IDX_LIM2 = 6'h19;
  localparam logic [5:0] IDX_STAT = 6'h1A;

  // Field positions
  localparam int CTRL_SMUTE = 6;
  localparam int CTRL_ZERO_RUN_MUTE_ENABLE = 2;
  localparam int CTRL_POL   = 0;
  localparam int LIM1_EN    = 8;
  localparam int LIM1_DCY   = 4;
  localparam int LIM1_ATK   = 0;
  localparam int LIM2_LVL   = 4;
  localparam int LIM2_BST   = 0;
  localparam int STAT_ZERO_RUN_MUTE_ENABLE = 0;
  localparam int STAT_ATT   = 8;

  // Reset values
  localparam logic [0:0] PWR_RST  = 1'h0;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] VOL_RST  = 8'hFF;
  localparam logic [8:0] LIM1_RST = 9'h032;
  localparam logic [6:0] LIM2_RST = 7'h00;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ---------------------------------------------------------------
  // Gain arithmetic
  // ---------------------------------------------------------------
  localparam logic [7:0]      VOL_MUTE  = 8'h00;
  localparam logic [7:0]      VOL_FULL  = 8'hFF;
  localparam logic [ATTW:0]   STEPS_6DB = 11'h00C;  // Half-dB steps per 6 dB
  localparam logic [ATTW:0]   BOOST_OFS = 11'h018;  // Headroom for +12 dB
  localparam logic [ATTW-1:0] SM_MAX    = 10'h100;  // Soft mute fully down
  localparam logic [ATTW-1:0] LIM_MAX   = 10'h060;  // Limiter floor, 48 dB
  localparam logic [3:0]      BST_MAX   = 4'hC;
  localparam logic [3:0]      RATE_CAP  = 4'hB;
  localparam logic [2:0]      LVL_CAP   = 3'h5;
  localparam logic [10:0]     ZRUN_LEN  = 11'h400;  // 1024 zero samples

  // 10^(-k/40) in Q1.15, one entry per half-dB within an octave
  localparam logic [15:0] FRAC_TAB [0:11] = '{
    16'h8000, 16'h78D7, 16'h7215, 16'h6BB3, 16'h65AD, 16'h5FFD,
    16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};

  // Magnitudes at -0.5 dB ... -6.5 dB of full scale, 1 dB apart
  localparam logic [22:0] THR_TAB [0:6] = '{
    23'h78D6E3, 23'h6BB32E, 23'h5FFC6D, 23'h558C47,
    23'h4C3E90, 23'h43F3D9, 23'h3C902A};

  // ---------------------------------------------------------------
  // Limiter rates, per 6 dB at the reference sample rate
  // ---------------------------------------------------------------
  localparam longint ATK_BASE_NS = 94000;
  localparam longint DCY_BASE_NS = 750000;
  localparam longint REF_RATE_HZ = 44100;
  localparam longint NS_PER_S    = 1000000000;
  localparam int     FRAC_BITS   = 16;
  localparam logic [19:0] ATK_INC0 = 20'((longint'(12) * (longint'(1) << FRAC_BITS)
                                     * NS_PER_S) / (ATK_BASE_NS * REF_RATE_HZ));
  localparam logic [19:0] DCY_INC0 = 20'((longint'(12) * (longint'(1) << FRAC_BITS)
                                     * NS_PER_S) / (DCY_BASE_NS * REF_RATE_HZ));

endpackage : pdp_pkg

// [design/pdp_playback_path.sv]
// Playback digital path: AXI4-Lite registers, volume, soft mute,
// limiter, polarity and zero-run mute ahead of the modulator.
// Samples arrive as a one-cycle strobe from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pdp_playback_path
  import pdp_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axil_awaddr,
  input  wire logic          s_axil_awvalid,
  output logic               s_axil_awready,
  input  wire logic [31:0]   s_axil_wdata,
  input  wire logic [3:0]    s_axil_wstrb,
  input  wire logic          s_axil_wvalid,
  output logic               s_axil_wready,
  output logic [1:0]         s_axil_bresp,
  output logic               s_axil_bvalid,
  input  wire logic          s_axil_bready,
  input  wire logic [AW-1:0] s_axil_araddr,
  input  wire logic          s_axil_arvalid,
  output logic               s_axil_arready,
  output logic [31:0]        s_axil_rdata,
  output logic [1:0]         s_axil_rresp,
  output logic               s_axil_rvalid,
  input  wire logic          s_axil_rready,
  input  wire logic [DW-1:0] playback_data_in,
  input  wire logic          playback_data_valid,
  output logic [DW-1:0]      converter_data_out,
  output logic               converter_data_valid,
  output logic               converter_active,
  output logic               output_mute
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic            pwr_ff,  nxt_pwr;
  logic [6:0]      ctrl_ff, nxt_ctrl;
  logic [7:0]      vol_ff,  nxt_vol;
  logic [8:0]      lim1_ff, nxt_lim1;
  logic [6:0]      lim2_ff, nxt_lim2;
  logic            aw_ff,   nxt_aw;
  logic [5:0]      awi_ff,  nxt_awi;
  logic            w_ff,    nxt_w;
  logic [31:0]     wd_ff,   nxt_wd;
  logic [3:0]      ws_ff,   nxt_ws;
  logic            bv_ff,   nxt_bv;
  logic [1:0]      br_ff,   nxt_br;
  logic            rv_ff,   nxt_rv;
  logic [31:0]     rd_ff,   nxt_rd;
  logic [1:0]      rr_ff,   nxt_rr;
  logic [31:0]     wmask;
  logic [31:0]     merged;
  logic [5:0]      ari;
  logic [ATTW-1:0] lim_att;

  assign s_axil_awready = !aw_ff && !bv_ff;
  assign s_axil_wready  = !w_ff && !bv_ff;
  assign s_axil_bvalid  = bv_ff;
  assign s_axil_bresp   = br_ff;
  assign s_axil_arready = !rv_ff;
  assign s_axil_rvalid  = rv_ff;
  assign s_axil_rdata   = rd_ff;
  assign s_axil_rresp   = rr_ff;

  // Address and data are latched separately, so either may come first
  always_comb
  begin
    nxt_pwr  = pwr_ff;
    nxt_ctrl = ctrl_ff;
    nxt_vol  = vol_ff;
    nxt_lim1 = lim1_ff;
    nxt_lim2 = lim2_ff;
    nxt_aw   = aw_ff;
    nxt_awi  = awi_ff;
    nxt_w    = w_ff;
    nxt_wd   = wd_ff;
    nxt_ws   = ws_ff;
    nxt_bv   = bv_ff;
    nxt_br   = br_ff;
    nxt_rv   = rv_ff;
    nxt_rd   = rd_ff;
    nxt_rr   = rr_ff;
    wmask    = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};
    merged   = '0;
    ari      = s_axil_araddr[AW-1:2];
    if (s_axil_awvalid && s_axil_awready)
    begin
      nxt_aw  = 1'b1;
      nxt_awi = s_axil_awaddr[AW-1:2];
    end
    if (s_axil_wvalid && s_axil_wready)
    begin
      nxt_w  = 1'b1;
      nxt_wd = s_axil_wdata;
      nxt_ws = s_axil_wstrb;
    end
    // Commit once both halves are held; the response follows a cycle later
    if (aw_ff && w_ff)
    begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = RESP_OK;
      case (awi_ff)
        IDX_PWR:
        begin
          merged  = (wd_ff & wmask) | ({31'h0, pwr_ff} & ~wmask);
          nxt_pwr = merged[0];
        end
        IDX_CTRL:
        begin
          merged   = (wd_ff & wmask) | ({25'h0, ctrl_ff} & ~wmask);
          nxt_ctrl = merged[6:0];
        end
        IDX_VOL:
        begin
          merged  = (wd_ff & wmask) | ({24'h0, vol_ff} & ~wmask);
          nxt_vol = merged[7:0];
        end
        IDX_LIM1:
        begin
          merged   = (wd_ff & wmask) | ({23'h0, lim1_ff} & ~wmask);
          nxt_lim1 = merged[8:0];
        end
        IDX_LIM2:
        begin
          merged   = (wd_ff & wmask) | ({25'h0, lim2_ff} & ~wmask);
          nxt_lim2 = merged[6:0];
        end
        IDX_STAT: nxt_br = RESP_OK;              // Read-only, write ignored
        default:  nxt_br = RESP_ERR;
      endcase
    end
    if (bv_ff && s_axil_bready)
      nxt_bv = 1'b0;
    if (s_axil_arvalid && s_axil_arready)
    begin
      nxt_rv = 1'b1;
      nxt_rr = RESP_OK;
      case (ari)
        IDX_PWR:  nxt_rd = {31'h0, pwr_ff};
        IDX_CTRL: nxt_rd = {25'h0, ctrl_ff};
        IDX_VOL:  nxt_rd = {24'h0, vol_ff};
        IDX_LIM1: nxt_rd = {23'h0, lim1_ff};
        IDX_LIM2: nxt_rd = {25'h0, lim2_ff};
        IDX_STAT: nxt_rd = {14'h0, lim_att, 7'h00, output_mute};
        default:
        begin
          nxt_rd = '0;
          nxt_rr = RESP_ERR;
        end
      endcase
    end
    else if (rv_ff && s_axil_rready)
      nxt_rv = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwr_ff  <= PWR_RST;
      ctrl_ff <= CTRL_RST;
      vol_ff  <= VOL_RST;
      lim1_ff <= LIM1_RST;
      lim2_ff <= LIM2_RST;
      aw_ff   <= 1'b0;
      awi_ff  <= '0;
      w_ff    <= 1'b0;
      wd_ff   <= '0;
      ws_ff   <= '0;
      bv_ff   <= 1'b0;
      br_ff   <= RESP_OK;
      rv_ff   <= 1'b0;
      rd_ff   <= '0;
      rr_ff   <= RESP_OK;
    end
    else
    begin
      pwr_ff  <= nxt_pwr;
      ctrl_ff <= nxt_ctrl;
      vol_ff  <= nxt_vol;
      lim1_ff <= nxt_lim1;
      lim2_ff <= nxt_lim2;
      aw_ff   <= nxt_aw;
      awi_ff  <= nxt_awi;
      w_ff    <= nxt_w;
      wd_ff   <= nxt_wd;
      ws_ff   <= nxt_ws;
      bv_ff   <= nxt_bv;
      br_ff   <= nxt_br;
      rv_ff   <= nxt_rv;
      rd_ff   <= nxt_rd;
      rr_ff   <= nxt_rr;
    end
  end

  // ---------------------------------------------------------------
  // Gain: volume, soft mute, limiter and boost in one dB sum
  // ---------------------------------------------------------------
  logic                   run;
  logic [ATTW-1:0]        sm_ff, nxt_sm;
  logic [3:0]             bst;
  logic signed [ATTW:0]   att_net;
  logic [GW-1:0]          gain;
  logic                   gain_zero;

  assign run = pwr_ff;
  assign bst = (lim2_ff[LIM2_BST +: 4] > BST_MAX) ? BST_MAX : lim2_ff[LIM2_BST +: 4];

  always_comb
  begin
    nxt_sm = sm_ff;
    if (!run)
      nxt_sm = ctrl_ff[CTRL_SMUTE] ? SM_MAX : '0;
    else if (playback_data_valid && ctrl_ff[CTRL_SMUTE] && sm_ff != SM_MAX)
      nxt_sm = sm_ff + 1'b1;
    else if (playback_data_valid && !ctrl_ff[CTRL_SMUTE] && sm_ff != '0)
      nxt_sm = sm_ff - 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sm_ff <= '0;
    else
      sm_ff <= nxt_sm;
  end

  // half-dB volume steps
  // Boost counts twice since it is set in whole dB
  assign att_net = $signed({1'b0, 10'(VOL_FULL - vol_ff)})
                 + $signed({1'b0, sm_ff}) + $signed({1'b0, lim_att})
                 - $signed({6'h00, bst, 1'b0});
  assign gain_zero = (vol_ff == VOL_MUTE) || (sm_ff == SM_MAX);

  pdp_db2lin u_db2lin (
    .att_net (att_net),
    .gain    (gain)
  );

  // ---------------------------------------------------------------
  // Sample path and zero-run mute
  // ---------------------------------------------------------------
  logic [DW-1:0]          out_ff, nxt_out;
  logic                   ov_ff,  nxt_ov;
  logic [10:0]            zc_ff,  nxt_zc;
  logic signed [DW+GW:0]  prod;
  logic signed [DW+GW:0]  scaled;
  logic signed [DW-1:0]   sat;
  logic [22:0]            mag;

  localparam logic signed [DW-1:0] SMAX = {1'b0, {(DW-1){1'b1}}};
  localparam logic signed [DW-1:0] SMIN = {1'b1, {(DW-1){1'b0}}};

  // volume and limiter ahead of modulation
  // full 24-bit result, saturated not wrapped
  always_comb
  begin
    prod   = $signed(playback_data_in) * $signed({1'b0, gain});
    scaled = prod >>> UNITY_SH;
    if (gain_zero)
      sat = '0;
    else if (scaled > (DW+GW+1)'(SMAX))
      sat = SMAX;
    else if (scaled < (DW+GW+1)'(SMIN))
      sat = SMIN;
    else
      sat = scaled[DW-1:0];
    nxt_ov  = run && playback_data_valid;
    nxt_out = out_ff;
    if (!run)
      nxt_out = '0;
    else if (playback_data_valid)
      nxt_out = (ctrl_ff[CTRL_POL] && sat != SMIN) ? -sat :
                (ctrl_ff[CTRL_POL] ? SMAX : sat);
    nxt_zc = zc_ff;
    if (!run)
      nxt_zc = '0;
    else if (playback_data_valid && playback_data_in != '0)
      nxt_zc = '0;
    else if (playback_data_valid && zc_ff != ZRUN_LEN)
      nxt_zc = zc_ff + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_ff <= '0;
      ov_ff  <= 1'b0;
      zc_ff  <= '0;
    end
    else
    begin
      out_ff <= nxt_out;
      ov_ff  <= nxt_ov;
      zc_ff  <= nxt_zc;
    end
  end

  assign converter_data_out   = out_ff;
  assign converter_data_valid = ov_ff;
  assign converter_active     = run;
  assign output_mute = ctrl_ff[CTRL_ZERO_RUN_MUTE_ENABLE] && (zc_ff == ZRUN_LEN);

  // Level seen by the limiter is the magnitude just sent out
  assign mag = (out_ff == SMIN) ? 23'h7FFFFF : out_ff[DW-1] ? 23'(~out_ff + 1'b1) : out_ff[22:0];

  pdp_limiter u_limiter (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick     (ov_ff),
    .mag      (mag),
    .run      (run),
    .enable   (lim1_ff[LIM1_EN]),
    .atk_code (lim1_ff[LIM1_ATK +: 4]),
    .dcy_code (lim1_ff[LIM1_DCY +: 4]),
    .lvl_code (lim2_ff[LIM2_LVL +: 3]),
    .att      (lim_att)
  );

endmodule : pdp_playback_path
`default_nettype wire

// [dv/pdp_checker.sv]
// Port checker for the playback path: bus handshakes, sample timing, mute.
// Assumes it is bound to pdp_playback_path; sees top-level ports only.
`timescale 1ns/1ps
`default_nettype none
module pdp_checker
  import pdp_pkg::*;
(
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axil_awvalid,
  input wire logic          s_axil_awready,
  input wire logic          s_axil_wvalid,
  input wire logic          s_axil_wready,
  input wire logic          s_axil_bvalid,
  input wire logic          s_axil_bready,
  input wire logic          s_axil_arvalid,
  input wire logic          s_axil_arready,
  input wire logic          s_axil_rvalid,
  input wire logic          s_axil_rready,
  input wire logic [31:0]   s_axil_rdata,
  input wire logic [DW-1:0] playback_data_in,
  input wire logic          playback_data_valid,
  input wire logic          converter_data_valid,
  input wire logic          converter_active,
  input wire logic          output_mute
);
  // ----------------------------------------------------------------
  // Zero-run shadow count, saturating so a long silence stays muted
  // ----------------------------------------------------------------
  logic [10:0] zc_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !converter_active)
      zc_ff <= 11'h000;
    else if (playback_data_valid)
      zc_ff <= (playback_data_in != '0) ? 11'h000 : ((zc_ff == 11'h400) ? zc_ff : zc_ff + 11'h001);
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid) else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata)) else $error("read answer unstable");
  a_write_block: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready) else $error("write taken while answering");
  a_read_block: assert property (s_axil_rvalid |-> !s_axil_arready) else $error("read taken while answering");
  a_read_latency: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid) else $error("read answer late");
  a_write_latency: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##2 s_axil_bvalid) else $error("write answer late");
  a_sample_fwd: assert property (playback_data_valid && converter_active |=> converter_data_valid) else $error("sample lost");
  a_sample_cause: assert property (converter_data_valid |-> $past(playback_data_valid)) else $error("output without input");
  a_path_idle: assert property (!converter_active |=> !converter_data_valid) else $error("output while disabled");
  a_mute_run: assert property (output_mute && converter_active |-> zc_ff == 11'h400) else $error("mute before zero run");
  a_mute_release: assert property (playback_data_valid && converter_active && playback_data_in != '0 |=> !output_mute) else $error("mute held");
endmodule : pdp_checker
`default_nettype wire

// [dv/pdp_playback_path_bench.sv]
// Self-checking bench: AXI4-Lite master, sample source, output monitor.
// Assumes pdp_src and pdp_checker are compiled alongside the design.
`timescale 1ns/1ps
`default_nettype none
module pdp_playback_path_bench
  import pdp_pkg::*;
;
  logic          aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready;
  logic          s_axil_arvalid, s_axil_rready, s_axil_awready, s_axil_wready;
  logic          s_axil_bvalid, s_axil_arready, s_axil_rvalid, playback_data_valid;
  logic          converter_data_valid, converter_active, output_mute;
  logic [AW-1:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0]   s_axil_wdata, s_axil_rdata;
  logic [3:0]    s_axil_wstrb;
  logic [1:0]    s_axil_bresp, s_axil_rresp;
  logic [DW-1:0] playback_data_in, converter_data_out, v, e;
  logic [7:0]    gap;
  logic [33:0]   q_r[$], er;
  logic [1:0]    q_b[$];
  logic [DW:0]   q_s[$], es;
  int            n_mismatch, check_count;
  always #4 aclk = ~aclk;
  pdp_playback_path uut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
    .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .playback_data_in,
    .playback_data_valid, .converter_data_out, .converter_data_valid, .converter_active,
    .output_mute);
  pdp_src src (.aclk, .aresetn, .gap, .playback_data_in, .playback_data_valid);
  // ----------------------------------------------------------------
  // Compare, report, finish
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (x !== g)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Bus master: holds each channel until its own ready, answers last
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q_b.push_back(r);
    s_axil_awaddr <= a; s_axil_wdata <= d; s_axil_wstrb <= 4'hF;
    s_axil_awvalid <= 1'b1; s_axil_wvalid <= 1'b1; s_axil_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    s_axil_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q_r.push_back({r, d});
    s_axil_araddr <= a; s_axil_arvalid <= 1'b1; s_axil_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    s_axil_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // Sample with its expected output; sk marks a ramp sample not compared
  task automatic smp(input logic [DW-1:0] x, input logic [DW-1:0] y, input logic sk);
    src.put(x);
    q_s.push_back({sk, y});
  endtask : smp
  task automatic drain;
    wait (src.q.size() == 0 && q_s.size() == 0);
    repeat (4) @(posedge aclk);
  endtask : drain
  function automatic logic [DW-1:0] rs();
    logic [31:0] r;
    r = $urandom();
    return {{4{r[19]}}, r[19:1], 1'b0};
  endfunction : rs
  // Monitor: every answer takes the oldest note of its kind
  always @(posedge aclk)
  begin
    if (s_axil_bvalid && s_axil_bready) chk("bresp", q_b.pop_front(), s_axil_bresp);
    if (s_axil_rvalid && s_axil_rready)
    begin
      er = q_r.pop_front();
      chk("rresp", er[33:32], s_axil_rresp);
      chk("rdata", er[31:0], s_axil_rdata);
    end
    if (converter_data_valid)
    begin
      if (q_s.size() == 0) chk("unexpected_out", 32'h0, 32'h1);
      else
      begin
        es = q_s.pop_front();
        if (!es[DW]) chk("sample", es[DW-1:0], converter_data_out);
      end
    end
  end
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0; aresetn = 1'b0; gap = 8'h00; s_axil_awaddr = '0; s_axil_araddr = '0;
    s_axil_awvalid = 1'b0; s_axil_wvalid = 1'b0; s_axil_bready = 1'b0; s_axil_wdata = '0;
    s_axil_wstrb = 4'h0; s_axil_arvalid = 1'b0; s_axil_rready = 1'b0;
    void'($urandom(32'h7918B3CC));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd({IDX_PWR, 2'h0}, 32'h0, RESP_OK);
    rd({IDX_CTRL, 2'h0}, 32'h0, RESP_OK);
    rd({IDX_VOL, 2'h0}, 32'hFF, RESP_OK);
    rd({IDX_LIM1, 2'h0}, 32'h32, RESP_OK);
    rd(8'h70, 32'h0, RESP_ERR);
    wr(8'h70, 32'hFFFFFFFF, RESP_ERR);
    src.put(rs());
    drain();
    chk("converter_active", 32'h0, converter_active);
    $display("test reset done");
    wr({IDX_PWR, 2'h0}, 32'h1, RESP_OK);
    chk("converter_active", 32'h1, converter_active);
    // Gain steps: half, mute, unity, inverted, boosted x2 and x4
    for (int k = 0; k < 6; k++)
    begin
      wr({(k < 3) ? IDX_VOL : (k == 3) ? IDX_CTRL : IDX_LIM2, 2'h0},
         (k == 0) ? 32'hF3 : (k == 1) ? 32'h0 : (k == 2) ? 32'hFF : (k == 3) ? 32'h1 : (k == 4) ? 32'h6 : 32'hF, RESP_OK);
      gap <= 8'($urandom_range(0, 3));
      repeat (4)
      begin
        v = rs();
        e = (k == 0) ? {v[DW-1], v[DW-1:1]} : (k == 1) ? '0 : (k == 2) ? v : (k == 3) ? -v : (k == 4) ? -(v << 1) : -(v << 2);
        smp(v, e, 1'b0);
      end
      drain();
    end
    wr({IDX_LIM2, 2'h0}, 32'h0, RESP_OK);
    $display("test gain done");
    gap <= 8'h00;
    wr({IDX_CTRL, 2'h0}, 32'h40, RESP_OK);
    repeat (258) smp(rs(), '0, 1'b1);
    repeat (4) smp(rs(), '0, 1'b0);
    drain();
    wr({IDX_CTRL, 2'h0}, 32'h0, RESP_OK);
    repeat (258) smp(rs(), '0, 1'b1);
    repeat (4) begin v = rs(); smp(v, v, 1'b0); end
    drain();
    $display("test soft mute done");
    wr({IDX_CTRL, 2'h0}, 32'h4, RESP_OK);
    repeat (1023) smp('0, '0, 1'b0);
    drain();
    chk("output_mute", 32'h0, output_mute);
    smp('0, '0, 1'b0);
    drain();
    chk("output_mute", 32'h1, output_mute);
    smp(24'h000100, 24'h000100, 1'b0);
    drain();
    chk("output_mute", 32'h0, output_mute);
    wr({IDX_CTRL, 2'h0}, 32'h0, RESP_OK);
    $display("test automute done");
    wr({IDX_LIM1, 2'h0}, 32'h100, RESP_OK);
    rd({IDX_LIM1, 2'h0}, 32'h100, RESP_OK);
    repeat (8) begin v = rs(); smp(v, v, 1'b0); end
    repeat (700) smp(24'h7FFFFF, '0, 1'b1);
    drain();
    chk("limited", 32'h1, 32'(converter_data_out < 24'h7FFFFF));
    wr({IDX_LIM1, 2'h0}, 32'h0, RESP_OK);
    smp(24'h7FFFFF, 24'h7FFFFF, 1'b0);
    drain();
    rd({IDX_STAT, 2'h0}, 32'h0, RESP_OK);
    wr({IDX_PWR, 2'h0}, 32'h0, RESP_OK);
    src.put(rs());
    drain();
    $display("test limiter done");
    complete_run();
  end
endmodule : pdp_playback_path_bench
bind pdp_playback_path pdp_checker chk (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready,
  .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid,
  .s_axil_arready, .s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .playback_data_in,
  .playback_data_valid, .converter_data_valid, .converter_active, .output_mute);
`default_nettype wire

// [dv/pdp_src.sv]
// Sample source model standing in for the audio interface.
// Assumes the bench queues samples through put and sets the idle gap.
`timescale 1ns/1ps
`default_nettype none
module pdp_src
  import pdp_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    gap,
  output logic      [DW-1:0] playback_data_in,
  output logic               playback_data_valid
);
  logic [DW-1:0] q[$];
  // Queue one sample
  function automatic void put(input logic [DW-1:0] v);
    q.push_back(v);
  endfunction : put
  // One strobe per sample; lines keep toggling outside it so stale reads show
  initial
  begin
    playback_data_in = '0;
    playback_data_valid = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (aresetn && q.size() > 0)
      begin
        playback_data_in <= q.pop_front();
        playback_data_valid <= 1'b1;
        @(posedge aclk);
        playback_data_valid <= 1'b0;
        playback_data_in <= ~playback_data_in;
        repeat (gap) @(posedge aclk) playback_data_in <= ~playback_data_in;
      end
      else
        playback_data_in <= ~playback_data_in;
    end
  end
endmodule : pdp_src
`default_nettype wire
